// file: design/swc_map.vh
`ifndef SWC_MAP_VH
`define SWC_MAP_VH
// ----------------------------------------
// Wake cause codes
// ----------------------------------------
`define SWC_CAUSE_NONE     2'h0
`define SWC_CAUSE_RESET    2'h1
`define SWC_CAUSE_WATCHDOG 2'h2
`define SWC_CAUSE_IRQ      2'h3
// ----------------------------------------
// Vector and source layout
// ----------------------------------------
`define SWC_IRQ_VECTOR     13'h0004
`define SWC_SRC_COUNT      8
`define SWC_SRC_TIMER1     0
`define SWC_SRC_RECEIVE    1
`define SWC_SRC_ADC        2
`define SWC_SRC_CHANGE     3
`define SWC_SRC_EXT_PIN    4
`define SWC_SRC_CAPTURE1   5
`define SWC_SRC_CAPTURE2   6
`define SWC_SRC_SERIAL     7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SWC_PD_RESET       1'b1
`define SWC_TO_RESET       1'b1
`endif

// file: design/swc_wake_gate.v
`timescale 1ns/1ps
`include "swc_map.vh"
module swc_wake_gate #(
  parameter N = `SWC_SRC_COUNT
) (
  input  wire [N-1:0] flags,
  input  wire [N-1:0] enables,
  input  wire [N-1:0] capable,
  output wire         irq_wake
);
  // Clockless OR of enabled, sleep-capable pending sources
  assign irq_wake = |(flags & enables & capable);
endmodule // swc_wake_gate

// file: design/swc_sleep_wakeup_control.v
`timescale 1ns/1ps
`include "swc_map.vh"
// Summary of operation
// - Wake from sleep on reset pin, enabled watchdog, or interrupt.
// - Reset-pin wake fully resets; watchdog and interrupt wakes resume execution.
// - Power-down flag set at power-up, cleared by sleep instruction.
// - Time-out flag cleared on a watchdog wake.
// - Timer-one wakes only as an asynchronous counter.
// - Receive interrupt wakes only in synchronous slave mode.
// - Conversion completion wakes only with internal RC clock.
// - Pin change, external pin and both capture units may wake.
// - Serial port wakes only as SPI or I2C slave.
// - No other peripheral interrupts while asleep.
// - Sleep instruction prefetches the instruction at next address.
// - Interrupt wakes need individual enable, regardless of global enable.
// - Global enable clear: resume after sleep without vectoring.
// - Global enable set: execute next instruction, then branch to vector.
// - Pending enabled source at sleep wakes immediately; sleep still completes.
// - Watchdog counter cleared on every wake.
// - Sleep with watchdog enabled clears counter, leaves it running.
// - Entering sleep sets time-out flag.
// - Entering sleep turns off the main oscillator driver.
module swc_sleep_wakeup_control #(
  parameter N = `SWC_SRC_COUNT
) (
  // Clock, reset and core side
  input  wire         ref_clk,
  input  wire         reset,
  input  wire         power_up,
  input  wire         sleep_exec,
  input  wire [12:0]  pc,
  // Wake sources and watchdog
  input  wire         external_reset_pin_n,
  input  wire         watchdog_enable,
  input  wire         watchdog_timeout,
  input  wire         global_interrupt_enable,
  input  wire [N-1:0] irq_flags,
  input  wire [N-1:0] irq_enables,
  // Sleep-capable qualifiers
  input  wire         timer_one_async,
  input  wire         receive_sync_slave,
  input  wire         adc_rc_clock,
  input  wire         sync_serial_port_slave,
  // Sleep state and status
  output reg          asleep,
  output wire         osc_driver_on,
  output reg          power_down_flag,
  output reg          time_out_flag,
  output wire         watchdog_clear,
  output wire         device_reset,
  output wire         wake_request,
  // Resume control
  output reg          prefetch_valid,
  output reg  [12:0]  prefetch_addr,
  output reg          vector_pending,
  output reg  [12:0]  vector_addr,
  output reg  [1:0]   wake_cause,
  output wire         peripheral_clk_en
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_RUN   = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_WAKE  = 2'h2;

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  reg  [1:0]   state;
  reg  [1:0]   next_state;
  wire [N-1:0] capable;
  wire         irq_wake;
  wire         rst_req;
  wire         wdt_wake;
  wire         wake_evt;
  wire         sleep_take;
  wire         wdt_clr_entry;
  wire         wdt_clr_wake;
  reg          next_asleep;
  reg          next_power_down_flag;
  reg          next_time_out_flag;
  reg          next_prefetch_valid;
  reg  [12:0]  next_prefetch_addr;
  reg          next_vector_pending;
  reg  [1:0]   next_wake_cause;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Sleep instruction is only taken while running
  function take_sleep;
    input       exec;
    input [1:0] st;
    begin
      take_sleep = exec & (st == ST_RUN);
    end
  endfunction

  // Wake event only counts while asleep
  function take_wake;
    input       evt;
    input [1:0] st;
    begin
      take_wake = evt & (st == ST_SLEEP);
    end
  endfunction

  // ----------------------------------------
  // Wake qualification
  // ----------------------------------------
  // Timer one keeps counting only as an asynchronous counter
  assign capable[`SWC_SRC_TIMER1]   = timer_one_async;

  // Receiver clocked from outside only as synchronous slave
  assign capable[`SWC_SRC_RECEIVE]  = receive_sync_slave;

  // Converter needs its own RC clock to finish
  assign capable[`SWC_SRC_ADC]      = adc_rc_clock;

  // Pin change, external pin and captures need no clock
  assign capable[`SWC_SRC_CHANGE]   = 1'b1;
  assign capable[`SWC_SRC_EXT_PIN]  = 1'b1;
  assign capable[`SWC_SRC_CAPTURE1] = 1'b1;
  assign capable[`SWC_SRC_CAPTURE2] = 1'b1;

  // Serial port clocked from outside only as slave
  assign capable[`SWC_SRC_SERIAL]   = sync_serial_port_slave;

  // Enable-gated OR, global enable not involved
  swc_wake_gate #(.N(N)) u_gate (
    .flags    (irq_flags),
    .enables  (irq_enables),
    .capable  (capable),
    .irq_wake (irq_wake)
  );

  // Reset pin request, active low
  assign rst_req      = ~external_reset_pin_n;

  // Watchdog wake only while enabled
  assign wdt_wake     = watchdog_enable & watchdog_timeout;

  // Any wake event, no clock needed
  assign wake_evt     = rst_req | wdt_wake | irq_wake;

  // Wake request only from the sleeping state
  assign wake_request = take_wake(wake_evt, state);

  // Reset pin forces a full device reset
  assign device_reset = rst_req;

  // ----------------------------------------
  // Clock gating toward the core
  // ----------------------------------------
  // Oscillator driver off in sleep
  assign osc_driver_on     = (state != ST_SLEEP);

  // Peripheral clocks follow the oscillator
  assign peripheral_clk_en = osc_driver_on;

  // ----------------------------------------
  // Sleep entry and watchdog clear
  // ----------------------------------------
  // Sleep instruction accepted
  assign sleep_take = take_sleep(sleep_exec, state);

  // Counter cleared on sleep entry, keeps running
  assign wdt_clr_entry = sleep_take;

  // Counter cleared on every wake
  assign wdt_clr_wake = wake_request;

  // Either clear reaches the watchdog
  assign watchdog_clear = wdt_clr_entry | wdt_clr_wake;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // Running: wait for the sleep instruction
        if (sleep_exec) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Asleep: wait for any wake event
        if (wake_evt) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Waking: one cycle, then resume
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // State register, reset pin wake forces full reset
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= ST_RUN;
    end else if (rst_req) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Asleep next value, reset pin always wins
  always @* begin
    next_asleep = (next_state == ST_SLEEP) & ~rst_req;
  end

  // Asleep indication register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      asleep <= 1'b0;
    end else begin
      asleep <= next_asleep;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Power-down flag next value
  always @* begin
    next_power_down_flag = power_down_flag;
    if (power_up) begin
      next_power_down_flag = 1'b1;
    end else if (sleep_take) begin
      next_power_down_flag = 1'b0;
    end
  end

  // Power-down flag register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      power_down_flag <= `SWC_PD_RESET;
    end else begin
      power_down_flag <= next_power_down_flag;
    end
  end

  // Time-out flag next value, power-up wins over watchdog wake
  always @* begin
    next_time_out_flag = time_out_flag;
    if (power_up) begin
      next_time_out_flag = 1'b1;
    end else if (wake_request & wdt_wake & ~rst_req) begin
      next_time_out_flag = 1'b0;
    end else if (sleep_take) begin
      next_time_out_flag = 1'b1;
    end
  end

  // Time-out flag register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      time_out_flag <= `SWC_TO_RESET;
    end else begin
      time_out_flag <= next_time_out_flag;
    end
  end

  // ----------------------------------------
  // Prefetch and resume
  // ----------------------------------------
  // Next instruction fetched during sleep instruction
  always @* begin
    next_prefetch_valid = prefetch_valid;
    next_prefetch_addr  = prefetch_addr;
    if (rst_req) begin
      next_prefetch_valid = 1'b0;
    end else if (sleep_take) begin
      next_prefetch_valid = 1'b1;
      next_prefetch_addr  = pc + 13'h0001;
    end else if (state == ST_WAKE) begin
      next_prefetch_valid = 1'b0;
    end
  end

  // Prefetch registers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prefetch_valid <= 1'b0;
      prefetch_addr  <= 13'h0000;
    end else begin
      prefetch_valid <= next_prefetch_valid;
      prefetch_addr  <= next_prefetch_addr;
    end
  end

  // Resume decision taken at the wake edge
  always @* begin
    next_vector_pending = vector_pending;
    next_wake_cause     = wake_cause;
    if (rst_req) begin
      next_vector_pending = 1'b0;
      next_wake_cause     = `SWC_CAUSE_RESET;
    end else if (wake_request) begin
      if (wdt_wake) begin
        next_vector_pending = 1'b0;
        next_wake_cause     = `SWC_CAUSE_WATCHDOG;
      end else begin
        // Clear: continue after sleep; set: one instruction then vector
        next_vector_pending = global_interrupt_enable;
        next_wake_cause     = `SWC_CAUSE_IRQ;
      end
    end else if (sleep_take) begin
      next_vector_pending = 1'b0;
      next_wake_cause     = `SWC_CAUSE_NONE;
    end
  end

  // Resume registers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vector_pending <= 1'b0;
      wake_cause     <= `SWC_CAUSE_NONE;
    end else begin
      vector_pending <= next_vector_pending;
      wake_cause     <= next_wake_cause;
    end
  end

  // Interrupt vector address, fixed
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vector_addr <= `SWC_IRQ_VECTOR;
    end else begin
      vector_addr <= `SWC_IRQ_VECTOR;
    end
  end
endmodule // swc_sleep_wakeup_control

// file: testbench/swc_props.sv
`timescale 1ns/1ps
module swc_props #(
  parameter N = 8
) (
  input wire         ref_clk,
  input wire         reset,
  input wire         external_reset_pin_n,
  input wire         watchdog_enable,
  input wire         watchdog_timeout,
  input wire         global_interrupt_enable,
  input wire         timer_one_async,
  input wire         receive_sync_slave,
  input wire         adc_rc_clock,
  input wire         sync_serial_port_slave,
  input wire         asleep,
  input wire         osc_driver_on,
  input wire         peripheral_clk_en,
  input wire         power_down_flag,
  input wire         time_out_flag,
  input wire         watchdog_clear,
  input wire         device_reset,
  input wire         wake_request,
  input wire         prefetch_valid,
  input wire         vector_pending,
  input wire [12:0]  pc,
  input wire [12:0]  prefetch_addr,
  input wire [12:0]  vector_addr,
  input wire [N-1:0] irq_flags,
  input wire [N-1:0] irq_enables,
  input wire [1:0]   wake_cause
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Sources that still run without clocks
  wire [7:0] able = {sync_serial_port_slave, 4'hF, adc_rc_clock, receive_sync_slave, timer_one_async};
  wire irq_hit = |(irq_flags & irq_enables & able);
  wire wd_hit = watchdog_enable & watchdog_timeout;
  sequence s_entry; $rose(asleep); endsequence
  sequence s_irq_wake; asleep && external_reset_pin_n && !wd_hit && irq_hit; endsequence
  property p_pin; device_reset == !external_reset_pin_n; endproperty
  property p_enter; s_entry |-> !power_down_flag && time_out_flag && !osc_driver_on
    && prefetch_addr == $past(pc) + 13'h1; endproperty
  property p_dark; asleep |-> !osc_driver_on && !peripheral_clk_en; endproperty
  property p_req; asleep && external_reset_pin_n |-> wake_request == (irq_hit || wd_hit); endproperty
  property p_clr; wake_request |-> watchdog_clear; endproperty
  property p_clr_in; s_entry |-> $past(watchdog_clear); endproperty
  property p_wd; asleep && external_reset_pin_n && wd_hit |=> !time_out_flag && wake_cause == 2'h2;
  endproperty
  property p_vec; s_irq_wake |=> wake_cause == 2'h3 && vector_addr == 13'h0004
    && vector_pending == $past(global_interrupt_enable); endproperty
  property p_now; s_entry ##0 irq_hit |=> !asleep ##[1:3] !prefetch_valid; endproperty
  a_pin: assert property (p_pin) else $error("reset pin not passed on");
  a_enter: assert property (p_enter) else $error("bad sleep entry");
  a_dark: assert property (p_dark) else $error("clock running asleep");
  a_req: assert property (p_req) else $error("bad wake request");
  a_clr: assert property (p_clr) else $error("watchdog not cleared on wake");
  a_clr_in: assert property (p_clr_in) else $error("watchdog not cleared on entry");
  a_wd: assert property (p_wd) else $error("bad watchdog wake");
  a_vec: assert property (p_vec) else $error("bad interrupt wake");
  a_now: assert property (p_now) else $error("pending source not waking");
endmodule // swc_props
bind swc_sleep_wakeup_control swc_props #(.N(N)) u_props (.*);

// file: testbench/swc_src_model.sv
`timescale 1ns/1ps
module swc_src_model (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire [7:0] raise,
  input  wire       drop,
  output reg  [7:0] irq_flags
);
  // Flags stick until the core clears them
  always @(posedge ref_clk or posedge reset) begin
    if (reset) irq_flags <= 8'h00;
    else irq_flags <= drop ? 8'h00 : (irq_flags | raise);
  end
endmodule // swc_src_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg ref_clk = 0, reset = 1, power_up = 0, sleep_exec = 0, external_reset_pin_n = 1, drop = 0;
  reg watchdog_enable = 0, watchdog_timeout = 0, global_interrupt_enable = 0;
  reg timer_one_async = 0, receive_sync_slave = 0, adc_rc_clock = 0, sync_serial_port_slave = 0;
  reg [12:0] pc = 13'h0000;
  reg [7:0] irq_enables = 8'h00, raise = 8'h00, gated = 8'h87;
  wire [7:0] irq_flags;
  wire asleep, osc_driver_on, power_down_flag, time_out_flag, watchdog_clear, device_reset;
  wire wake_request, prefetch_valid, vector_pending, peripheral_clk_en;
  wire [12:0] prefetch_addr, vector_addr;
  wire [1:0] wake_cause;
  integer err_count = 0, samples_checked = 0, cycles = 0, i;
  swc_sleep_wakeup_control DUT (
    .ref_clk                 (ref_clk),
    .reset                   (reset),
    .power_up                (power_up),
    .sleep_exec              (sleep_exec),
    .pc                      (pc),
    .external_reset_pin_n    (external_reset_pin_n),
    .watchdog_enable         (watchdog_enable),
    .watchdog_timeout        (watchdog_timeout),
    .global_interrupt_enable (global_interrupt_enable),
    .irq_flags               (irq_flags),
    .irq_enables             (irq_enables),
    .timer_one_async         (timer_one_async),
    .receive_sync_slave      (receive_sync_slave),
    .adc_rc_clock            (adc_rc_clock),
    .sync_serial_port_slave  (sync_serial_port_slave),
    .asleep                  (asleep),
    .osc_driver_on           (osc_driver_on),
    .power_down_flag         (power_down_flag),
    .time_out_flag           (time_out_flag),
    .watchdog_clear          (watchdog_clear),
    .device_reset            (device_reset),
    .wake_request            (wake_request),
    .prefetch_valid          (prefetch_valid),
    .prefetch_addr           (prefetch_addr),
    .vector_pending          (vector_pending),
    .vector_addr             (vector_addr),
    .wake_cause              (wake_cause),
    .peripheral_clk_en       (peripheral_clk_en)
  );
  swc_src_model SRC (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .raise     (raise),
    .drop      (drop),
    .irq_flags (irq_flags)
  );
  // Clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task step(input integer n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task chk(input [8*8-1:0] name, input [12:0] seen, input [12:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected %0s exp %h seen %h", name, exp, seen);
    end
  endtask
  task nap(input [12:0] p);
    pc = p;
    sleep_exec = 1;
    step(1);
    sleep_exec = 0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Test sequence
  initial begin
    step(10);
    reset = 0;
    step(1);
    chk("pd_rst", power_down_flag, 1);
    nap(13'h0ABC);
    chk("pd_slp", power_down_flag, 0);
    chk("to_slp", time_out_flag, 1);
    chk("prefetch", prefetch_addr, 13'h0ABD);
    chk("osc", osc_driver_on, 0);
    chk("pclk", peripheral_clk_en, 0);
    chk("pf_val", prefetch_valid, 1);
    $display("test entry done");
    for (i = 0; i < 8; i = i + 1) begin
      global_interrupt_enable = i[0];
      irq_enables = 8'h00;
      raise = 8'h01 << i;
      step(1);
      raise = 8'h00;
      step(3);
      chk("masked", asleep, 1);
      irq_enables = 8'hFF;
      step(3);
      chk("gated", asleep, gated[i]);
      {sync_serial_port_slave, adc_rc_clock, receive_sync_slave, timer_one_async} = 4'hF;
      step(3);
      chk("woken", asleep, 0);
      chk("cause", wake_cause, 2'h3);
      chk("vec", vector_pending, i[0]);
      chk("vec_addr", vector_addr, 13'h0004);
      {sync_serial_port_slave, adc_rc_clock, receive_sync_slave, timer_one_async} = 4'h0;
      drop = 1;
      step(1);
      drop = 0;
      nap(13'h0100);
    end
    $display("test sources done");
    watchdog_timeout = 1;
    step(2);
    chk("wd_off", asleep, 1);
    watchdog_enable = 1;
    #1;
    chk("wake_req", wake_request, 1);
    chk("wd_clr", watchdog_clear, 1);
    step(3);
    watchdog_timeout = 0;
    chk("to_wd", time_out_flag, 0);
    chk("cause_wd", wake_cause, 2'h2);
    irq_enables = 8'h08;
    raise = 8'h08;
    step(1);
    raise = 8'h00;
    nap(13'h0200);
    step(3);
    chk("pending", asleep, 0);
    chk("pd_pend", power_down_flag, 0);
    chk("c_pend", wake_cause, 2'h3);
    chk("v_pend", vector_pending, 1);
    chk("pf_done", prefetch_valid, 0);
    drop = 1;
    step(1);
    drop = 0;
    nap(13'h0300);
    external_reset_pin_n = 0;
    step(1);
    chk("rst_out", device_reset, 1);
    chk("cause_r", wake_cause, 2'h1);
    external_reset_pin_n = 1;
    power_up = 1;
    step(1);
    power_up = 0;
    step(1);
    chk("pd_pwr", power_down_flag, 1);
    $display("test wake causes done");
    give_verdict;
  end
endmodule // tb_top
